// [rtl/sac_pkg.sv]
// Constants and carrier types for the converter control and serial readout
//
// Functional notes
// R01: Range input low is shutdown, high unipolar, floating bipolar.
// R02: Serial result leaves most significant bit first.
// R03: End-of-conversion rests low, high during conversion or calibration.
// R04: Active-low chip select enables serial port and drives data output.
// R05: Acquired input: conversion starts at next conversion-clock falling edge.
// R06: Early convert-start waits for the falling edge after acquisition completes.
// R07: Reset held low keeps device inactive, no conversion or calibration.
// R08: Reset rising edge reinitialises control and starts calibration at once.
// R09: Host toggles shift clock between conversions; device advances output on it.
// R10: Shift clock domain is independent of the conversion clock.
// R11: Host waits 3.2 us after leaving shutdown before trusting results.
// R12: Calibration lasts about 14,000 conversion clocks, end-of-conversion high.
// R13: Three clocks since last end: start next edge, else fourth edge.
// R14: Further convert-start pulses are ignored while converting.
// R15: Bits readable during conversion at clock rate, or after on shift clock.
// R16: Result is 14 bits; output floats after last bit or chip deselect.
// R17: Host drives convert-start synchronous with the conversion clock.
package sac_pkg;

    localparam int unsigned RES_BITS     = 14;
    localparam int unsigned CAL_CYCLES   = 14000;
    localparam int unsigned ACQ_CYCLES   = 3;
    localparam int unsigned CNT_W        = 14;
    localparam int unsigned BIT_W        = 4;
    localparam logic [3:0]  MSB_INDEX    = 4'hd;

    // Decoded three-level range input
    typedef enum logic [1:0] {
        SAC_RNG_SHDN = 2'h0,
        SAC_RNG_UNI  = 2'h1,
        SAC_RNG_BIP  = 2'h2
    } sac_range_e;

    typedef enum logic [3:0] {
        SAC_ST_IDLE = 4'h1,
        SAC_ST_CAL  = 4'h2,
        SAC_ST_WAIT = 4'h4,
        SAC_ST_CONVERT_START_N = 4'h8
    } sac_state_e;

    // Result handed from conversion domain to shift domain
    typedef struct packed {
        logic                bipolar;
        logic [RES_BITS-1:0] code;
    } sac_result_s;

endpackage

// [rtl/sac_shift_out.sv]
// Serial shift register on the host's shift clock
`timescale 1ns/1ps
module sac_shift_out (
    // Shift clock domain
    input  wire logic                          i_sclk,
    input  wire logic                          i_rst,
    // Result from the conversion domain
    input  wire logic                          i_load_tgl,
    input  wire logic [sac_pkg::RES_BITS-1:0]  i_code,
    // Serial interface
    input  wire logic                          i_cs_n,
    output logic                               o_bit,
    output logic                               o_bit_valid
);
    logic                         tgl_s1_q;
    logic                         tgl_s2_q;
    logic                         tgl_s3_q;
    logic [sac_pkg::RES_BITS-1:0] sh_q;
    logic [sac_pkg::BIT_W-1:0]    left_q;

    // Code settles in the same clock the toggle flips and holds steady while the toggle crosses two shift-clock stages
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= i_load_tgl; // R10
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            sh_q   <= '0;
            left_q <= '0;
        end else if (tgl_s2_q != tgl_s3_q) begin
            sh_q   <= i_code;
            left_q <= sac_pkg::BIT_W'(sac_pkg::RES_BITS); // R16
        end else if (!i_cs_n && left_q != '0) begin
            sh_q   <= {sh_q[sac_pkg::RES_BITS-2:0], 1'b0}; // R09 R02
            left_q <= left_q - 1'b1;
        end
    end

    assign o_bit       = sh_q[sac_pkg::RES_BITS-1];
    assign o_bit_valid = (left_q != '0);
endmodule

// [rtl/sac_top.sv]
// Conversion control, calibration timing and serial readout of the converter
`timescale 1ns/1ps
module sac_top (
    // Conversion clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_ce,
    // Host pins on the conversion side
    input  wire logic                          i_reset_n,
    input  wire logic                          i_convert_start_n,
    input  wire logic                          i_rng_drive,
    input  wire logic                          i_rng_level,
    // Comparator decision from the analog array
    input  wire logic                          i_cmp_bit,
    // Serial side
    input  wire logic                          i_sclk,
    input  wire logic                          i_cs_n,
    // Outputs
    output logic                               o_eoc,
    output logic                               o_dout,
    output logic                               o_dout_oe,
    output logic                               o_shutdown,
    output logic                               o_bipolar,
    output logic [sac_pkg::RES_BITS-1:0]       o_result
);
    logic [1:0]                   rst_sync_q;
    logic [1:0]                   convert_start_n_sync_q;
    logic [1:0]                   drv_sync_q;
    logic [1:0]                   lvl_sync_q;
    logic [1:0]                   cs_sync_q;
    logic                         reset_n_d1_q;
    sac_pkg::sac_state_e          state_q;
    logic [sac_pkg::CNT_W-1:0]    cnt_q;
    logic [sac_pkg::BIT_W-1:0]    bit_q;
    logic [1:0]                   since_q;
    logic                         pend_q;
    sac_pkg::sac_result_s         res_q;
    logic                         load_tgl_q;
    logic                         sh_bit;
    logic                         sh_valid;
    sac_pkg::sac_range_e          range_d;
    logic                         start_req;

    // Falling-edge semantics: the design samples host pins on i_clk, which
    // stands for the falling edge of the converter clock
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_sync_q  <= 2'h0;
            convert_start_n_sync_q <= 2'h3;
            drv_sync_q  <= 2'h0;
            lvl_sync_q  <= 2'h0;
            cs_sync_q   <= 2'h3;
        end else if (i_ce) begin
            rst_sync_q  <= {rst_sync_q[0], i_reset_n};
            convert_start_n_sync_q <= {convert_start_n_sync_q[0], i_convert_start_n};
            drv_sync_q  <= {drv_sync_q[0], i_rng_drive};
            lvl_sync_q  <= {lvl_sync_q[0], i_rng_level};
            cs_sync_q   <= {cs_sync_q[0], i_cs_n};
        end
    end

    // Undriven pin reads as floating: bipolar
    always_comb begin
        if (!drv_sync_q[1]) begin
            range_d = sac_pkg::SAC_RNG_BIP; // R01
        end else if (lvl_sync_q[1]) begin
            range_d = sac_pkg::SAC_RNG_UNI;
        end else begin
            range_d = sac_pkg::SAC_RNG_SHDN;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_shutdown   <= 1'b1;
            o_bipolar    <= 1'b0;
            reset_n_d1_q <= 1'b0;
        end else if (i_ce) begin
            o_shutdown   <= (range_d == sac_pkg::SAC_RNG_SHDN); // R01
            o_bipolar    <= (range_d == sac_pkg::SAC_RNG_BIP);
            reset_n_d1_q <= rst_sync_q[1];
        end
    end

    // Held request covers a short pulse that lands while acquiring
    assign start_req = !convert_start_n_sync_q[1] || pend_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q    <= sac_pkg::SAC_ST_IDLE;
            cnt_q      <= '0;
            bit_q      <= '0;
            since_q    <= '0;
            pend_q     <= 1'b0;
            res_q      <= '0;
            load_tgl_q <= 1'b0;
        end else if (i_ce) begin
            if (!rst_sync_q[1]) begin
                state_q <= sac_pkg::SAC_ST_IDLE; // R07
                pend_q  <= 1'b0;
                since_q <= '0;
                cnt_q   <= '0;
            end else if (!reset_n_d1_q) begin
                state_q <= sac_pkg::SAC_ST_CAL; // R08
                cnt_q   <= '0;
                pend_q  <= 1'b0;
            end else begin
                case (state_q)
                    sac_pkg::SAC_ST_CAL: begin
                        if (cnt_q == sac_pkg::CNT_W'(
                                sac_pkg::CAL_CYCLES - 1)) begin
                            state_q <= sac_pkg::SAC_ST_WAIT; // R12
                            since_q <= '0;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    sac_pkg::SAC_ST_WAIT: begin
                        if (since_q != 2'(sac_pkg::ACQ_CYCLES)) begin
                            since_q <= since_q + 1'b1;
                        end
                        if (start_req && !o_shutdown) begin
                            if (since_q == 2'(sac_pkg::ACQ_CYCLES)) begin
                                state_q    <= sac_pkg::SAC_ST_CONVERT_START_N; // R05 R13
                                bit_q      <= sac_pkg::MSB_INDEX;
                                pend_q     <= 1'b0;
                            end else begin
                                pend_q <= 1'b1; // R06 R13
                            end
                        end
                    end
                    sac_pkg::SAC_ST_CONVERT_START_N: begin
                        // Convert-start ignored here
                        res_q.code[bit_q] <= i_cmp_bit; // R14 R02
                        if (bit_q == '0) begin
                            state_q        <= sac_pkg::SAC_ST_WAIT;
                            since_q        <= '0;
                            res_q.bipolar  <= o_bipolar;
                            load_tgl_q     <= ~load_tgl_q; // R09
                        end else begin
                            bit_q <= bit_q - 1'b1;
                        end
                    end
                    sac_pkg::SAC_ST_IDLE: begin
                        state_q <= sac_pkg::SAC_ST_IDLE;
                    end
                    default: begin
                        state_q <= sac_pkg::SAC_ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_eoc    <= 1'b0;
            o_result <= '0;
        end else if (i_ce) begin
            o_eoc    <= (state_q == sac_pkg::SAC_ST_CAL) ||
                        (state_q == sac_pkg::SAC_ST_CONVERT_START_N); // R03 R12
            o_result <= res_q.code;
        end
    end

    sac_shift_out sac_shift_out_inst (
        .i_sclk      (i_sclk),
        .i_rst       (i_rst),
        .i_load_tgl  (load_tgl_q),
        .i_code      (res_q.code),
        .i_cs_n      (i_cs_n),
        .o_bit       (sh_bit),
        .o_bit_valid (sh_valid)
    );

    // During conversion each decided bit appears at clock rate; afterwards
    // the shift register output is sampled here so outputs stay registered.
    // Trade-off: serial data lags the shift clock by three system clocks.
    logic [1:0] sh_bit_q;
    logic [1:0] sh_val_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_bit_q  <= 2'h0;
            sh_val_q  <= 2'h0;
            o_dout    <= 1'b0;
            o_dout_oe <= 1'b0;
        end else if (i_ce) begin
            sh_bit_q <= {sh_bit_q[0], sh_bit};
            sh_val_q <= {sh_val_q[0], sh_valid};
            if (state_q == sac_pkg::SAC_ST_CONVERT_START_N) begin
                o_dout    <= i_cmp_bit; // R15
                o_dout_oe <= !cs_sync_q[1]; // R04
            end else begin
                o_dout    <= sh_bit_q[1]; // R02
                o_dout_oe <= !cs_sync_q[1] && sh_val_q[1]; // R04 R16
            end
        end
    end
endmodule

// [verif/sac_checker.sv]
// Concurrent checks on the converter control pins
`timescale 1ns/1ps
module sac_checker (
    // Clock and resets
    input wire logic                         i_clk,
    input wire logic                         i_rst,
    input wire logic                         i_reset_n,
    // Host pins
    input wire logic                         i_rng_drive,
    input wire logic                         i_cs_n,
    // Device outputs
    input wire logic                         o_eoc,
    input wire logic                         o_dout_oe,
    input wire logic                         o_shutdown,
    input wire logic                         o_bipolar,
    input wire logic [sac_pkg::RES_BITS-1:0] o_result
);
    // Length of the current busy run, judged when it ends
    logic [13:0] run_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_q <= 14'h0;
        end else begin
            run_q <= o_eoc ? run_q + 14'h1 : 14'h0;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_eoc_run_len: assert property (
        $fell(o_eoc) |-> run_q == 14'he ||
        run_q == 14'(sac_pkg::CAL_CYCLES)) else $error("busy run length");
    chk_cal_start: assert property (
        $rose(i_reset_n) |-> ##[2:5] o_eoc) else $error("no calibration");
    chk_reset_idle: assert property (
        !i_reset_n [*4] |-> !o_eoc) else $error("busy while held");
    chk_eoc_gap: assert property (
        $fell(o_eoc) |-> !o_eoc [*3]) else $error("acquisition too short");
    chk_shdn_block: assert property (
        o_shutdown && $past(o_shutdown) && !o_eoc && i_reset_n &&
        $past(i_reset_n, 6) |=> !o_eoc) else $error("start in shutdown");
    chk_range_bip: assert property (
        !i_rng_drive [*4] |-> o_bipolar && !o_shutdown)
        else $error("floating range");
    chk_oe_cs: assert property (
        i_cs_n [*4] |-> !o_dout_oe) else $error("drive while deselected");
    chk_result_hold: assert property (
        !o_eoc && !$past(o_eoc) && !$past(o_eoc, 2) && i_reset_n
        |-> $stable(o_result)) else $error("result changed while idle");
endmodule

// [verif/sac_host_model.sv]
// Host model: comparator source, chip select and serial shift clock
`timescale 1ns/1ps
module sac_host_model (
    // Conversion domain
    input  wire logic        i_clk,
    input  wire logic        i_eoc,
    input  wire logic [13:0] i_pattern,
    // Serial port
    input  wire logic        i_dout,
    input  wire logic        i_dout_oe,
    output logic             o_sclk,
    output logic             o_cs_n,
    output logic             o_cmp
);
    int k = 0;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_cmp  = 1'b0;
    end
    // One decision per clock, most significant first; idle holds the first bit, toggling only past the 14th while busy
    always @(negedge i_clk) begin
        k = i_eoc ? k + 1 : 0;
        o_cmp = (k < 14) ? i_pattern[13-k] : ~o_cmp;
    end
    // Shift clock only runs inside a frame, offset from the other clock
    task automatic frame(output logic [13:0] v, output int n);
        v = 14'h0;
        n = 0;
        o_cs_n = 1'b0;
        #107;
        repeat (20) begin
            o_sclk = 1'b1;
            #80;
            o_sclk = 1'b0;
            #80;
            if (i_dout_oe === 1'b1) begin
                v = {v[12:0], i_dout};
                n++;
            end
        end
        o_cs_n = 1'b1;
    endtask
endmodule

// [verif/tb_sac_top.sv]
// Self-checking bench for the converter control and readout
`timescale 1ns/1ps
module tb_sac_top;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        rst_n = 1'b0;
    logic        convert_start_n_n = 1'b1;
    logic        drv = 1'b1;
    logic        lvl = 1'b1;
    logic        sclk, cs_n, cmp, eoc, dout, oe, shdn, bip;
    logic [13:0] res, v;
    logic [13:0] pat = 14'h0;
    int          n_fail = 0;
    int          compares = 0;
    int          n;
    sac_top sac_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_reset_n(rst_n), .i_convert_start_n(convert_start_n_n), .i_rng_drive(drv),
        .i_rng_level(lvl), .i_cmp_bit(cmp), .i_sclk(sclk), .i_cs_n(cs_n),
        .o_eoc(eoc), .o_dout(dout), .o_dout_oe(oe), .o_shutdown(shdn),
        .o_bipolar(bip), .o_result(res));
    sac_host_model sac_host_model_inst (.i_clk(i_clk), .i_eoc(eoc),
        .i_pattern(pat), .i_dout(dout), .i_dout_oe(oe), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_cmp(cmp));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge i_clk);
    endtask
    task automatic wait_eoc(input logic l, output int c);
        c = 0;
        while (eoc !== l && c < 20000) begin
            @(negedge i_clk);
            c++;
        end
        if (eoc !== l) n_fail++;
    endtask
    task automatic t_cal;
        rst_n = 1'b1;
        wait_eoc(1'b1, n);
        chk(16'(n <= 5), 16'h1);
        wait_eoc(1'b0, n);
        chk(16'(n), 16'(sac_pkg::CAL_CYCLES));
    endtask
    task automatic t_convert_start_n(input logic [13:0] p);
        pat = p;
        cyc(10);
        convert_start_n_n = 1'b0;
        cyc(2);
        convert_start_n_n = 1'b1;
        wait_eoc(1'b1, n);
        chk(16'(n + 2), 16'h4);
        cyc(3);
        convert_start_n_n = 1'b0;
        cyc(2);
        convert_start_n_n = 1'b1;
        wait_eoc(1'b0, n);
        chk(16'(n + 5), 16'he);
        cyc(10);
        chk(16'(eoc), 16'h0);
        chk(16'(res), 16'(p));
    endtask
    task automatic t_back(input logic [13:0] p);
        pat = p;
        convert_start_n_n = 1'b0;
        wait_eoc(1'b1, n);
        wait_eoc(1'b0, n);
        wait_eoc(1'b1, n);
        chk(16'(n >= 3 && n <= 6), 16'h1);
        convert_start_n_n = 1'b1;
        wait_eoc(1'b0, n);
        cyc(10);
        chk(16'(res), 16'(p));
    endtask
    task automatic t_read;
        sac_host_model_inst.frame(v, n);
        chk(16'(n), 16'he);
        chk(16'(v), 16'(pat));
        cyc(6);
        chk(16'(oe), 16'h0);
    endtask
    task automatic t_range;
        drv = 1'b0;
        cyc(5);
        chk({14'h0, shdn, bip}, 16'h1);
        drv = 1'b1;
        lvl = 1'b0;
        cyc(5);
        chk({14'h0, shdn, bip}, 16'h2);
        convert_start_n_n = 1'b0;
        cyc(10);
        convert_start_n_n = 1'b1;
        chk(16'(eoc), 16'h0);
        lvl = 1'b1;
        cyc(5);
        chk({14'h0, shdn, bip}, 16'h0);
        cyc(160);
    endtask
    task automatic t_reset;
        rst_n = 1'b0;
        cyc(4);
        convert_start_n_n = 1'b0;
        cyc(10);
        chk(16'(eoc), 16'h0);
        convert_start_n_n = 1'b1;
        cyc(4);
        t_cal();
    endtask
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #1000000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        cyc(5);
        i_rst = 1'b0;
        cyc(8);
        t_cal();
        t_convert_start_n(14'h2d36);
        t_back(14'h1c5a);
        t_read();
        t_range();
        t_convert_start_n(14'h3a91);
        t_reset();
        tally_and_finish();
    end
endmodule
bind sac_top sac_checker sac_checker_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_reset_n(i_reset_n), .i_rng_drive(i_rng_drive), .i_cs_n(i_cs_n),
    .o_eoc(o_eoc), .o_dout_oe(o_dout_oe), .o_shutdown(o_shutdown),
    .o_bipolar(o_bipolar), .o_result(o_result));
